// ### src/nvmc_ctrl.sv
/*
  Nonvolatile self-program controller: register file on Avalon-MM, byte
  writes to data memory, program reads and four-word block writes.
  Assumes the core skips instructions while cpu_skip is high and holds
  execution while cpu_stall is high; memory arrays act on start pulses.
*/
// Chosen here: register access over Avalon-MM and the register offsets.
// Behaviour
// R1: write starts only after 55h, AAh to unlock port, then write-go set.
// R2: write-go cannot be set while write-allow is clear.
// R3: hardware never clears write-allow.
// R4: clearing write-allow does not disturb a write in progress.
// R5: write end clears write-go and sets write-done flag.
// R6: firmware clears write-done flag; hardware keeps it set.
// R7: firmware loads address, byte and clears space-select before data write.
// R8: firmware should mask interrupts over the unlock sequence.
// R9: program read uses next two cycles; those two instructions are skipped.
// R10: read word lands in data registers, held until replaced.
// R11: program write only outside the protected region.
// R12: program writes go in aligned blocks of four words.
// R13: each block write is erase then write, never across blocks.
// R14: one sequence per word in order; first three only fill buffer.
// R15: word 11 erases the block and programs all four buffered words.
// R16: firmware fills all four buffer words, re-reading unchanged ones.
// R17: two cycles after write-go are setup; those instructions are skipped.
// R18: block erase stalls the core about 4 ms, clocks keep running.
// R19: execution resumes at the third instruction after write-go.
// R20: a sequence at a forbidden location is ignored.
// R21: firmware checks write-go clear before a new data write.
// R22: unlock port stores nothing and reads zero.
// R23: warm reset during a write sets abort flag, keeps address and data.
// R24: software only sets read-go and write-go; hardware clears them.
// R25: space-select is zero after reset and frozen during writes.
// R26: unlock needs consecutive writes; any other write restarts it.
`timescale 1ns/100ps
module nvmc_ctrl
  import nvmc_pkg::*;
#(
  parameter int ERASE_CYCLES = nvmc_pkg::ERASE_CYCLES_DFLT,
  parameter int EE_WR_CYCLES = nvmc_pkg::EE_WR_CYCLES_DFLT
)
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         warm_rst,
  // avalon-mm slave
  input  wire logic [4:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [3:0]                   avs_byteenable,
  input  wire logic [31:0]                  avs_writedata,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  // configuration
  input  wire logic [1:0]                   protect_region_sel,
  // core control
  output logic                              cpu_skip,
  output logic                              cpu_stall,
  output logic                              write_done_flag,
  // data memory array
  output logic                              ee_wr_start,
  output logic      [7:0]                   ee_wr_addr,
  output logic      [7:0]                   ee_wr_data,
  // program memory array
  output logic      [nvmc_pkg::ADDR_W-1:0]  flash_rd_addr,
  input  wire logic [nvmc_pkg::WORD_W-1:0]  flash_rd_data,
  output logic                              flash_block_start,
  output logic      [nvmc_pkg::ADDR_W-3:0]  flash_block_addr,
  output logic      [4*nvmc_pkg::WORD_W-1:0] flash_block_data,
  output logic                              nvm_abort
);
  import nvmc_pkg::*;

  initial
  begin
    if (ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << CNT_W) ||
        EE_WR_CYCLES < 1 || EE_WR_CYCLES >= (1 << CNT_W))
      $error("cycle counts out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic              ack;
  logic              space_select;
  logic              write_abort_flag;
  logic              write_allow;
  logic              write_go;
  logic              read_go;
  logic [7:0]        nvm_data_low;
  logic [5:0]        nvm_data_high;
  logic [7:0]        nvm_addr_low;
  logic [4:0]        nvm_addr_high;
  logic [WORD_W-1:0] buffer [0:3];
  nvmc_state_t       state;
  logic [CNT_W-1:0]  cnt;
  logic              armed;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: a request is taken on the edge where waitrequest is low
  wire logic              wr_take  = avs_write && ack && avs_byteenable[0];
  wire logic [7:0]        wd       = avs_writedata[7:0];
  wire logic              ctrl_wr  = wr_take && avs_address == OFS_CTRL;
  wire logic              unl_wr   = wr_take && avs_address == OFS_UNLOCK;
  wire logic [ADDR_W-1:0] full_adr = {nvm_addr_high, nvm_addr_low};
  wire logic [1:0]        word_sel = nvm_addr_low[1:0];
  wire logic              busy_wr  = (state == ST_EE_WRITE) || (state == ST_BLOCK);

  function automatic logic prot_hit(input logic [1:0] sel, input logic [ADDR_W-1:0] a);
    case (sel)
      2'h2:    prot_hit = (a < PROT_LIM_SEL2);
      2'h1:    prot_hit = (a < PROT_LIM_SEL1);
      2'h0:    prot_hit = (a < PROT_LIM_SEL0);
      default: prot_hit = 1'b0;
    endcase
  endfunction : prot_hit

  wire logic blocked = prot_hit(protect_region_sel, full_adr);
  // the armed state is consumed by this very control write
  // space select as this very control write leaves it, so one write may set space and go
  wire logic space_eff = (ctrl_wr && !write_go) ? wd[CTRL_SPACE] : space_select;
  wire logic go_set  = ctrl_wr && wd[CTRL_GO] && !write_go && !read_go && armed &&
                       write_allow;                                   // R1 R2
  wire logic rd_set  = ctrl_wr && wd[CTRL_RD] && !read_go && !write_go;

  // completion events
  wire logic fin_ee   = (state == ST_EE_WRITE) && cnt == '0;
  wire logic fin_blk  = (state == ST_BLOCK) && cnt == '0;
  wire logic fin_skip = (state == ST_WR_SKIP) && cnt == '0;
  wire logic go_blk   = fin_skip && word_sel == LAST_WORD;
  wire logic fin_rd   = (state == ST_RD_SKIP) && cnt == '0;
  wire logic done_evt = !warm_rst && (fin_ee || fin_blk || (fin_skip && !go_blk));

  nvmc_unlock u_unlock (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_take   (wr_take),
    .wr_unlock (unl_wr),
    .wdata     (wd),
    .armed     (armed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // avalon handshake and read mux
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ack          <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack <= (avs_read || avs_write) && !ack;
      if (avs_read && !ack)
      begin
        case (avs_address)
          OFS_CTRL:    avs_readdata <= {24'h000000, space_select, 3'h0,
                                        write_abort_flag, write_allow, write_go, read_go};
          OFS_UNLOCK:  avs_readdata <= 32'h0000_0000;                 // R22
          OFS_DATA_LO: avs_readdata <= {24'h000000, nvm_data_low};
          OFS_DATA_HI: avs_readdata <= {26'h0000000, nvm_data_high};
          OFS_ADDR_LO: avs_readdata <= {24'h000000, nvm_addr_low};
          OFS_ADDR_HI: avs_readdata <= {27'h0000000, nvm_addr_high};
          OFS_STATUS:  avs_readdata <= {31'h00000000, write_done_flag};
          default:     avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_waitrequest = !ack;

  ////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      space_select     <= 1'b0;                                       // R25
      write_abort_flag <= 1'b0;
      write_allow      <= 1'b0;
      write_go         <= 1'b0;
      read_go          <= 1'b0;
    end
    else if (warm_rst)
    begin
      space_select <= 1'b0;
      write_go     <= 1'b0;
      read_go      <= 1'b0;
      if (busy_wr || state == ST_WR_SKIP)
        write_abort_flag <= 1'b1;                                     // R23
    end
    else
    begin
      if (ctrl_wr)
      begin
        write_allow      <= wd[CTRL_ALLOW];                           // R3 R4
        write_abort_flag <= wd[CTRL_ABORT];
        if (!write_go)
          space_select <= wd[CTRL_SPACE];                             // R25
      end
      if (go_set)
        write_go <= 1'b1;
      else if (done_evt || (fin_skip && !go_blk))
        write_go <= 1'b0;                                             // R5 R24
      else if (state == ST_IDLE && write_go && space_select && blocked)
        write_go <= 1'b0;                                             // R20
      if (rd_set)
        read_go <= 1'b1;
      else if (fin_rd || (state == ST_IDLE && read_go && !space_select))
        read_go <= 1'b0;                                              // R24
    end
  end

  // set wins over a firmware clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      write_done_flag <= 1'b0;
    else if (done_evt)
      write_done_flag <= 1'b1;                                        // R5
    else if (wr_take && avs_address == OFS_STATUS && wd[STAT_DONE])
      write_done_flag <= 1'b0;                                        // R6
  end

  ////////////////////////////////////////////////////////////////////////////
  // address and data registers; warm reset leaves them alone
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      nvm_data_low  <= REG_RST;
      nvm_data_high <= REG_RST[5:0];
      nvm_addr_low  <= REG_RST;
      nvm_addr_high <= REG_RST[4:0];
      flash_rd_addr <= '0;
    end
    else
    begin
      flash_rd_addr <= full_adr;
      if (wr_take && avs_address == OFS_ADDR_LO && !write_go)
        nvm_addr_low <= wd;
      if (wr_take && avs_address == OFS_ADDR_HI && !write_go)
        nvm_addr_high <= wd[4:0];
      if (fin_rd && !warm_rst)
      begin
        nvm_data_low  <= flash_rd_data[7:0];                          // R10
        nvm_data_high <= flash_rd_data[WORD_W-1:8];
      end
      else
      begin
        if (wr_take && avs_address == OFS_DATA_LO)
          nvm_data_low <= wd;
        if (wr_take && avs_address == OFS_DATA_HI)
          nvm_data_high <= wd[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state             <= ST_IDLE;
      cnt               <= '0;
      cpu_skip          <= 1'b0;
      cpu_stall         <= 1'b0;
      ee_wr_start       <= 1'b0;
      ee_wr_addr        <= REG_RST;
      ee_wr_data        <= REG_RST;
      flash_block_start <= 1'b0;
      flash_block_addr  <= '0;
      flash_block_data  <= '0;
      nvm_abort         <= 1'b0;
      for (int i = 0; i < 4; i++)
        buffer[i] <= '0;
    end
    else
    begin
      ee_wr_start       <= 1'b0;
      flash_block_start <= 1'b0;
      nvm_abort         <= 1'b0;
      if (warm_rst)
      begin
        nvm_abort <= busy_wr;                                         // R23
        state     <= ST_IDLE;
        cpu_skip  <= 1'b0;
        cpu_stall <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            if (go_set && !space_eff)
            begin
              state       <= ST_EE_WRITE;
              cnt         <= CNT_W'(EE_WR_CYCLES - 1);
              ee_wr_start <= 1'b1;
              ee_wr_addr  <= nvm_addr_low;
              ee_wr_data  <= nvm_data_low;
            end
            else if (go_set && space_eff && !blocked)                 // R11 R20
            begin
              buffer[word_sel] <= {nvm_data_high, nvm_data_low};      // R12 R14
              state            <= ST_WR_SKIP;
              cnt              <= CNT_W'(SKIP_CYCLES - 1);
              cpu_skip         <= 1'b1;                               // R17
            end
            else if (rd_set && space_eff)
            begin
              state    <= ST_RD_SKIP;
              cnt      <= CNT_W'(SKIP_CYCLES - 1);
              cpu_skip <= 1'b1;                                       // R9
            end
          end
          ST_RD_SKIP, ST_WR_SKIP:
          begin
            cnt <= cnt - 1'b1;
            if (cnt == '0)
            begin
              cpu_skip <= 1'b0;
              state    <= ST_IDLE;
              if (go_blk)
              begin
                state             <= ST_BLOCK;                        // R15
                cnt               <= CNT_W'(ERASE_CYCLES - 1);
                cpu_stall         <= 1'b1;                            // R18
                flash_block_start <= 1'b1;                            // R13
                flash_block_addr  <= full_adr[ADDR_W-1:2];
                flash_block_data  <= {buffer[3], buffer[2], buffer[1], buffer[0]};
              end
            end
          end
          ST_EE_WRITE, ST_BLOCK:
          begin
            cnt <= cnt - 1'b1;
            if (cnt == '0)
            begin
              state     <= ST_IDLE;
              cpu_stall <= 1'b0;                                      // R19
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [CNT_W-1:0] stall_len;

  always_ff @(posedge clk)
  begin
    if (!rst_n || !cpu_stall)
      stall_len <= CNT_W'(1);
    else
      stall_len <= stall_len + 1'b1;
  end

  sequence s_rd_start;
    $rose(read_go) && space_select;
  endsequence

  sequence s_skip_two;
    cpu_skip [*2] ##1 !cpu_skip;
  endsequence

  a_go_unlocked: assert property (@(posedge clk) disable iff (!rst_n) // R1
    $rose(write_go) |-> $past(armed) && $past(write_allow) && $past(ctrl_wr))
    else $error("write-go set without unlock and allow");

  a_allow_sw_only: assert property (@(posedge clk) disable iff (!rst_n) // R3
    $changed(write_allow) |-> $past(ctrl_wr))
    else $error("write-allow changed by hardware");

  a_go_hw_clear: assert property (@(posedge clk) disable iff (!rst_n) // R24
    $fell(write_go) |-> $past(done_evt) || $past(warm_rst) ||
                        ($past(state) == ST_IDLE && $past(blocked)))
    else $error("write-go cleared by software");

  a_done_on_end: assert property (@(posedge clk) disable iff (!rst_n) // R5
    (fin_ee || fin_blk) && !warm_rst |=> write_done_flag && !write_go)
    else $error("write end did not flag done");

  a_unlock_zero: assert property (@(posedge clk) disable iff (!rst_n) // R22
    avs_read && !ack && avs_address == OFS_UNLOCK |=> avs_readdata == 32'h0000_0000)
    else $error("unlock port read nonzero");

  a_read_skip: assert property (@(posedge clk) disable iff (!rst_n || warm_rst) // R9
    s_rd_start |-> s_skip_two ##0 !read_go)
    else $error("program read skip timing wrong");

  a_stall_length: assert property (@(posedge clk) disable iff (!rst_n) // R18
    $fell(cpu_stall) && !$past(warm_rst) |-> $past(stall_len) == CNT_W'(ERASE_CYCLES))
    else $error("block stall length wrong");

  a_stall_after_skip: assert property (@(posedge clk) disable iff (!rst_n) // R17
    $rose(cpu_stall) |-> $past(cpu_skip, 1) && $past(cpu_skip, 2) && flash_block_start)
    else $error("stall not after two skipped cycles");

  a_prot_ignore: assert property (@(posedge clk) disable iff (!rst_n) // R20
    go_set && space_eff && blocked |=> (!cpu_skip && !flash_block_start) ##1
      (!cpu_skip && !write_go && !flash_block_start) [*3])
    else $error("protected write not ignored");

  a_space_frozen: assert property (@(posedge clk) disable iff (!rst_n || warm_rst) // R25
    write_go && $past(write_go) |-> $stable(space_select))
    else $error("space-select changed during write");

  a_abort_flag: assert property (@(posedge clk) disable iff (!rst_n) // R23
    warm_rst && busy_wr |=> write_abort_flag && nvm_abort && $stable(full_adr))
    else $error("abort not flagged on warm reset");

endmodule : nvmc_ctrl

// ### src/nvmc_pkg.sv
/*
  Shared constants for the nonvolatile self-program controller: register
  offsets, control bit positions, unlock keys, widths, timing and states.
  Assumes a 40 MHz clock where one clock equals one instruction cycle.
*/
package nvmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ           = 40;
  localparam int ERASE_TIME_US     = 4000;
  localparam int ERASE_CYCLES_DFLT = ERASE_TIME_US * CLK_MHZ;
  localparam int EE_WRITE_TIME_US  = 4000;
  localparam int EE_WR_CYCLES_DFLT = EE_WRITE_TIME_US * CLK_MHZ;
  localparam int SKIP_CYCLES       = 2;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int ADDR_W = 13;
  localparam int WORD_W = 14;
  localparam int CNT_W  = 20;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_UNLOCK  = 5'h04;
  localparam logic [4:0] OFS_DATA_LO = 5'h08;
  localparam logic [4:0] OFS_DATA_HI = 5'h0c;
  localparam logic [4:0] OFS_ADDR_LO = 5'h10;
  localparam logic [4:0] OFS_ADDR_HI = 5'h14;
  localparam logic [4:0] OFS_STATUS  = 5'h18;

  ////////////////////////////////////////////////////////////////////////////
  // control and status bit positions
  localparam int CTRL_SPACE = 7;
  localparam int CTRL_ABORT = 3;
  localparam int CTRL_ALLOW = 2;
  localparam int CTRL_GO    = 1;
  localparam int CTRL_RD    = 0;
  localparam int STAT_DONE  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // values
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam logic [1:0] LAST_WORD   = 2'h3;
  localparam logic [7:0] REG_RST     = 8'h00;
  localparam logic [ADDR_W-1:0] PROT_LIM_SEL2 = 13'h0100;
  localparam logic [ADDR_W-1:0] PROT_LIM_SEL1 = 13'h0800;
  localparam logic [ADDR_W-1:0] PROT_LIM_SEL0 = 13'h1000;

  ////////////////////////////////////////////////////////////////////////////
  // states
  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_ARMED} nvmc_unlock_t;
  typedef enum logic [2:0] {ST_IDLE, ST_RD_SKIP, ST_WR_SKIP, ST_EE_WRITE,
                            ST_BLOCK} nvmc_state_t;

endpackage : nvmc_pkg

// ### src/nvmc_unlock.sv
/*
  Unlock sequence detector: arms after a key1 write then a key2 write to
  the unlock port. Assumes one write strobe per accepted bus write.
*/
`timescale 1ns/100ps
module nvmc_unlock
  import nvmc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register writes
  input  wire logic       wr_take,
  input  wire logic       wr_unlock,
  input  wire logic [7:0] wdata,
  // result
  output logic            armed
);

  nvmc_unlock_t state;

  ////////////////////////////////////////////////////////////////////////////
  // any write that breaks the chain drops back to idle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= UL_IDLE;
    else if (wr_take)
    begin
      if (wr_unlock && wdata == UNLOCK_KEY1)                          // R26
        state <= UL_KEY1;
      else if (wr_unlock && wdata == UNLOCK_KEY2 && state == UL_KEY1) // R1
        state <= UL_ARMED;
      else
        state <= UL_IDLE;                                             // R26
    end
  end

  assign armed = (state == UL_ARMED);

  a_arm_order: assert property (@(posedge clk) disable iff (!rst_n) // R1
    $rose(armed) |-> $past(wr_take && wr_unlock && wdata == UNLOCK_KEY2))
    else $error("unlock armed without key2 write");

endmodule : nvmc_unlock

// ### tb/nvmc_mem_model.sv
/*
  Program array stand-in: word reads by address, four-word block programming.
  Assumes the controller holds block address and data with its start pulse.
*/
`timescale 1ns/100ps
module nvmc_mem_model
  import nvmc_pkg::*;
(
  // clock
  input  wire logic                          clk,
  // read side
  input  wire logic [nvmc_pkg::ADDR_W-1:0]   rd_addr,
  output logic      [nvmc_pkg::WORD_W-1:0]   rd_data,
  // block programming
  input  wire logic                          blk_start,
  input  wire logic [nvmc_pkg::ADDR_W-3:0]   blk_addr,
  input  wire logic [4*nvmc_pkg::WORD_W-1:0] blk_data
);
  logic [WORD_W-1:0] mem [2**ADDR_W];

  initial
  begin
    for (int i = 0; i < 2**ADDR_W; i++)
      mem[i] = {1'b0, ~13'(i)};
  end

  assign rd_data = mem[rd_addr];

  // whole aligned block is replaced at once, never a partial word set
  always @(posedge clk)
  begin
    if (blk_start === 1'b1)
      for (int k = 0; k < 4; k++)
        mem[{blk_addr, 2'(k)}] <= blk_data[k*WORD_W +: WORD_W];
  end
endmodule : nvmc_mem_model

// ### tb/nvmc_ctrl_bench.sv
/*
  Self-checking bench for nvmc_ctrl: Avalon tasks, register-level tests.
  Assumes nvmc_mem_model stands in for the program array.
*/
`timescale 1ns/100ps
module nvmc_ctrl_bench;
  import nvmc_pkg::*;
  localparam int ERC = 20;
  logic        clk = 0, rst_n = 0, warm_rst = 0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 0, avs_write = 0;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        avs_waitrequest, cpu_skip, cpu_stall, write_done_flag;
  logic        ee_wr_start, flash_block_start, nvm_abort;
  logic [1:0]  protect_region_sel = 2'h3;
  logic [7:0]  ee_wr_addr, ee_wr_data, v, hi;
  logic [12:0] flash_rd_addr, base;
  logic [13:0] flash_rd_data, w, wd;
  logic [10:0] flash_block_addr;
  logic [55:0] flash_block_data, blk;
  int num_errors = 0, samples_checked = 0;
  int n_ee = 0, n_blk = 0, n_skip = 0, n_stall = 0, n_abort = 0, s0;

  always #12.5 clk = ~clk;

  nvmc_ctrl #(.ERASE_CYCLES(ERC), .EE_WR_CYCLES(ERC)) nvmc_ctrl_inst (.clk, .rst_n,
    .warm_rst, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .protect_region_sel, .cpu_skip, .cpu_stall,
    .write_done_flag, .ee_wr_start, .ee_wr_addr, .ee_wr_data, .flash_rd_addr,
    .flash_rd_data, .flash_block_start, .flash_block_addr, .flash_block_data, .nvm_abort);

  nvmc_mem_model nvmc_mem_model_inst (.clk, .rd_addr(flash_rd_addr),
    .rd_data(flash_rd_data), .blk_start(flash_block_start),
    .blk_addr(flash_block_addr), .blk_data(flash_block_data));

  always @(posedge clk)
  begin
    if (ee_wr_start === 1'b1) n_ee++;
    if (flash_block_start === 1'b1) n_blk++;
    if (cpu_skip === 1'b1) n_skip++;
    if (cpu_stall === 1'b1) n_stall++;
    if (nvm_abort === 1'b1) n_abort++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk8

  task automatic chkw(input logic [55:0] g, input logic [55:0] e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chkw

  // extra edge after release so a following request never lands in the same step
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic seta(input logic [12:0] a);
    wr(OFS_ADDR_HI, {3'h0, a[12:8]});
    wr(OFS_ADDR_LO, a[7:0]);
  endtask : seta

  task automatic go(input logic [7:0] ctl);
    wr(OFS_UNLOCK, UNLOCK_KEY1);
    wr(OFS_UNLOCK, UNLOCK_KEY2);
    wr(OFS_CTRL, ctl);
  endtask : go

  task automatic wait_done;
    do rd(OFS_STATUS, v); while (v[STAT_DONE] !== 1'b1);
    rd(OFS_STATUS, v);
    chk8(v, 8'h01);
    chk8(8'(write_done_flag), 8'h01);
    wr(OFS_STATUS, 8'h01);
  endtask : wait_done

  task automatic pread(input logic [12:0] a, output logic [13:0] q);
    seta(a);
    s0 = n_skip;
    wr(OFS_CTRL, 8'h81);
    repeat (2) @(posedge clk);
    rd(OFS_DATA_LO, v);
    rd(OFS_DATA_HI, hi);
    q = {hi[5:0], v};
    chkw(56'(flash_rd_addr), 56'(a));
    chk8(8'(n_skip - s0), 8'd2);
  endtask : pread

  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_CTRL, v);
    chk8(v, REG_RST);
    wr(OFS_UNLOCK, UNLOCK_KEY1);
    rd(OFS_UNLOCK, v);
    chk8(v, 8'h00);
    $display("test reset_values done");
    seta(13'h003c);
    wr(OFS_DATA_LO, 8'ha5);
    go(8'h02);
    rd(OFS_CTRL, v);
    chk8(v, 8'h00);
    wr(OFS_CTRL, 8'h04);
    wr(OFS_UNLOCK, UNLOCK_KEY1);
    wr(OFS_DATA_LO, 8'ha5);
    wr(OFS_UNLOCK, UNLOCK_KEY2);
    wr(OFS_CTRL, 8'h06);
    rd(OFS_CTRL, v);
    chk8(v, 8'h04);
    chk8(8'(n_ee), 8'd0);
    $display("test refused_go done");
    go(8'h06);
    wr(OFS_CTRL, 8'h00);
    rd(OFS_CTRL, v);
    chk8(v, 8'h02);
    wait_done();
    chk8(8'(n_ee), 8'd1);
    chk8(ee_wr_addr, 8'h3c);
    chk8(ee_wr_data, 8'ha5);
    rd(OFS_CTRL, v);
    chk8(v, 8'h00);
    rd(OFS_STATUS, v);
    chk8(v, 8'h00);
    $display("test data_write done");
    pread(13'h1805, w);
    chkw(56'(w), 56'({1'b0, ~13'h1805}));
    $display("test program_read done");
    base = 13'h1804;
    wr(OFS_CTRL, 8'h84);
    for (int k = 0; k < 4; k++)
    begin
      wd = 14'(14'h1000 + k * 14'h0111);
      blk[k*14 +: 14] = wd;
      seta(base + 13'(k));
      wr(OFS_DATA_LO, wd[7:0]);
      wr(OFS_DATA_HI, {2'h0, wd[13:8]});
      s0 = n_skip;
      go(8'h86);
      wait_done();
      chk8(8'(n_skip - s0), 8'd2);
      chk8(8'(n_blk), (k == 3) ? 8'd1 : 8'd0);
    end
    chk8(8'(n_stall), 8'(ERC));
    chkw(flash_block_data, blk);
    chkw(56'(flash_block_addr), 56'(base[12:2]));
    pread(base + 13'h2, w);
    chkw(56'(w), 56'(blk[41:28]));
    $display("test block_write done");
    protect_region_sel <= 2'h0;
    seta(13'h0003);
    wr(OFS_CTRL, 8'h84);
    go(8'h86);
    repeat (4) @(posedge clk);
    rd(OFS_CTRL, v);
    chk8(v, 8'h84);
    rd(OFS_STATUS, v);
    chk8(v, 8'h00);
    chk8(8'(n_blk), 8'd1);
    pread(13'h0003, w);
    chkw(56'(w), 56'({1'b0, ~13'h0003}));
    $display("test protected_write done");
    wr(OFS_CTRL, 8'h04);
    seta(13'h0077);
    go(8'h06);
    warm_rst <= 1'b1;
    @(posedge clk);
    warm_rst <= 1'b0;
    rd(OFS_CTRL, v);
    chk8(v, 8'h0c);
    rd(OFS_ADDR_LO, v);
    chk8(v, 8'h77);
    chk8(8'(n_abort), 8'd1);
    $display("test warm_reset done");
    conclude();
  end

  initial
  begin
    #(25 * 20000);
    num_errors++;
    conclude();
  end
endmodule : nvmc_ctrl_bench
